// File: hw/sttm_timer.sv
// Ten-bit timer with duty and period comparators, capture and PWM.
// Assumes clock ticks are synchronous to I_CLOCK; the external clock and capture pins are synchronised here.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module sttm_timer (
    // Clock and reset.
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    // Register port.
    input wire logic [2:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WRITE,
    input wire logic I_READ,
    output logic [7:0] O_RDATA,
    // Internal clock ticks, one cycle per source clock period.
    input wire logic I_HIGH_CLK_TICK,
    input wire logic I_SUB_CLK_TICK,
    // Pins.
    input wire logic I_EXTERNAL_CLOCK_PIN,
    input wire logic I_CAPTURE_INPUT_PIN,
    output logic O_TIMER_OUTPUT_PIN,
    output logic O_TIMER_OUTPUT_OE_N,
    // Event pulses.
    output logic O_DUTY_MATCH_FLAG,
    output logic O_PERIOD_MATCH_FLAG
);
    // Whole state of the block.
    typedef struct packed {
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [9:0] cnt;
        logic [9:0] duty;
        logic [7:0] buffer;
        logic [7:0] rdata;
        logic out;
        logic flag_a;
        logic flag_p;
        logic pulse_run;
        logic [1:0] pre4;
        logic [5:0] pre_h;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic cap_s1;
        logic cap_s2;
        logic cap_s3;
    } sttm_state_s;

    sttm_state_s st_reg;
    sttm_state_s st_next;

    // Decoded control fields of the current state.
    logic on_bit;
    logic pause_bit;
    logic [2:0] clk_sel;
    logic [2:0] per_val;
    logic [1:0] mode;
    logic [1:0] func;
    logic oc_bit;
    logic pol_bit;
    logic swap_bit;
    logic clr_bit;
    assign on_bit = st_reg.ctl0[sttm_pkg::C0_ON];
    assign pause_bit = st_reg.ctl0[sttm_pkg::C0_PAUSE];
    assign clk_sel = st_reg.ctl0[sttm_pkg::C0_CLK_HI:sttm_pkg::C0_CLK_LO];
    assign per_val = st_reg.ctl0[sttm_pkg::C0_PER_HI:0];
    assign mode = st_reg.ctl1[sttm_pkg::C1_MODE_HI:sttm_pkg::C1_MODE_LO];
    assign func = st_reg.ctl1[sttm_pkg::C1_FUNC_HI:sttm_pkg::C1_FUNC_LO];
    assign oc_bit = st_reg.ctl1[sttm_pkg::C1_OC];
    assign pol_bit = st_reg.ctl1[sttm_pkg::C1_POL];
    assign swap_bit = st_reg.ctl1[sttm_pkg::C1_SWAP];
    assign clr_bit = st_reg.ctl1[sttm_pkg::C1_CLR];

    // Next-state logic for counter, comparators, output and registers.
    always_comb begin
        logic tick;
        logic ext_rise;
        logic ext_fall;
        logic cap_rise;
        logic cap_fall;
        logic cap_hit;
        logic cmp_like;
        logic run;
        logic [10:0] cnt_inc;
        logic a_hit;
        logic p_hit;
        logic wrap;
        logic on_rise;
        logic [10:0] duty_lim;
        logic spo;
        tick = 1'b0;
        ext_rise = 1'b0;
        ext_fall = 1'b0;
        cap_rise = 1'b0;
        cap_fall = 1'b0;
        cap_hit = 1'b0;
        cmp_like = 1'b0;
        run = 1'b0;
        cnt_inc = 11'h000;
        a_hit = 1'b0;
        p_hit = 1'b0;
        wrap = 1'b0;
        on_rise = 1'b0;
        duty_lim = 11'h000;
        spo = 1'b0;
        st_next = st_reg;
        st_next.flag_a = 1'b0;
        st_next.flag_p = 1'b0;
        st_next.rdata = 8'h00;
        // Only the edge detectors read the last stage of each chain.
        // synchroniser stages
        st_next.ext_s1 = I_EXTERNAL_CLOCK_PIN;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        st_next.cap_s1 = I_CAPTURE_INPUT_PIN;
        st_next.cap_s2 = st_reg.cap_s1;
        st_next.cap_s3 = st_reg.cap_s2;
        ext_rise = st_reg.ext_s2 & ~st_reg.ext_s3;
        ext_fall = ~st_reg.ext_s2 & st_reg.ext_s3;
        cap_rise = st_reg.cap_s2 & ~st_reg.cap_s3;
        cap_fall = ~st_reg.cap_s2 & st_reg.cap_s3;
        // Free-running prescalers for the divided sources.
        st_next.pre4 = st_reg.pre4 + 2'h1;
        if (I_HIGH_CLK_TICK) begin
            st_next.pre_h = st_reg.pre_h + 6'h01;
        end
        unique case (clk_sel)
            sttm_pkg::CK_SYS4: tick = (st_reg.pre4 == sttm_pkg::DIV4_LAST);
            sttm_pkg::CK_SYS: tick = 1'b1;
            sttm_pkg::CK_H16: tick = I_HIGH_CLK_TICK &&
                ((st_reg.pre_h & sttm_pkg::DIV16_MASK) ==
                 sttm_pkg::DIV16_MASK);
            sttm_pkg::CK_H64: tick = I_HIGH_CLK_TICK &&
                (st_reg.pre_h == sttm_pkg::DIV64_LAST);
            sttm_pkg::CK_SUB0: tick = I_SUB_CLK_TICK;
            sttm_pkg::CK_SUB1: tick = I_SUB_CLK_TICK;
            sttm_pkg::CK_EXT_R: tick = ext_rise;
            sttm_pkg::CK_EXT_F: tick = ext_fall;
        endcase
        cmp_like = (mode == sttm_pkg::MODE_CMP) ||
                   (mode == sttm_pkg::MODE_TMR);
        spo = (mode == sttm_pkg::MODE_PWM) && (func == sttm_pkg::FN_3);
        // count only when on and not paused
        run = on_bit && !pause_bit && tick && (!spo || st_reg.pulse_run);
        cnt_inc = {1'b0, st_reg.cnt} + 11'h001;
        // period match on the top three bits
        p_hit = (cnt_inc[9:0] == {per_val, sttm_pkg::PER_LOW_ZERO});
        // full ten-bit duty compare, zero never matches
        a_hit = (cnt_inc[9:0] == st_reg.duty) &&
                (st_reg.duty != sttm_pkg::CNT_RESET);
        if (cmp_like) begin
            wrap = clr_bit ? a_hit : p_hit;
        end else if (mode == sttm_pkg::MODE_PWM && swap_bit) begin
            wrap = a_hit;
        end else begin
            wrap = p_hit;
        end
        if (run) begin
            st_next.cnt = wrap ? sttm_pkg::CNT_RESET : cnt_inc[9:0];
            // event pulses on matches and overflow
            st_next.flag_a = a_hit && (mode != sttm_pkg::MODE_CAP);
            // no period flag while duty clears
            st_next.flag_p = p_hit && !(cmp_like && clr_bit);
        end
        if (run && a_hit && mode == sttm_pkg::MODE_CMP) begin
            unique case (func)
                sttm_pkg::FN_0: st_next.out = st_reg.out;
                sttm_pkg::FN_1: st_next.out = 1'b0;
                sttm_pkg::FN_2: st_next.out = 1'b1;
                sttm_pkg::FN_3: st_next.out = ~st_reg.out;
            endcase
        end
        // Swapped roles make the period comparator set the duty limit.
        // duty limit from either comparator
        if (swap_bit) begin
            duty_lim = (per_val == 3'h0) ? sttm_pkg::FULL_PERIOD :
                       {1'b0, per_val, sttm_pkg::PER_LOW_ZERO};
        end else begin
            duty_lim = {1'b0, st_reg.duty};
        end
        if (mode == sttm_pkg::MODE_PWM && on_bit) begin
            unique case (func)
                sttm_pkg::FN_0: st_next.out = ~oc_bit;
                sttm_pkg::FN_1: st_next.out = oc_bit;
                sttm_pkg::FN_2: st_next.out =
                    ({1'b0, st_next.cnt} < duty_lim) ? oc_bit : ~oc_bit;
                sttm_pkg::FN_3: begin
                    // Trigger edge starts a pulse, duty match ends it.
                    // A trigger is ignored while paused, so the count holds.
                    if (!st_reg.pulse_run && ext_rise && !pause_bit) begin
                        st_next.pulse_run = 1'b1;
                        st_next.cnt = sttm_pkg::CNT_RESET;
                        st_next.out = oc_bit;
                    end else if (run && a_hit) begin
                        st_next.pulse_run = 1'b0;
                        st_next.out = ~oc_bit;
                    end
                end
            endcase
        end
        if (mode == sttm_pkg::MODE_CAP && on_bit) begin
            unique case (func)
                sttm_pkg::FN_0: cap_hit = cap_rise;
                sttm_pkg::FN_1: cap_hit = cap_fall;
                sttm_pkg::FN_2: cap_hit = cap_rise | cap_fall;
                sttm_pkg::FN_3: cap_hit = 1'b0;
            endcase
        end
        if (cap_hit) begin
            st_next.duty = st_reg.cnt;
            st_next.flag_a = 1'b1;
        end
        // Register writes; the counter bytes ignore writes.
        if (I_WRITE) begin
            unique case (I_ADDR)
                sttm_pkg::OFF_CTL0: begin
                    st_next.ctl0 = I_WDATA;
                    on_rise = I_WDATA[sttm_pkg::C0_ON] && !on_bit;
                end
                sttm_pkg::OFF_CTL1: st_next.ctl1 = I_WDATA;
                // low byte goes to the buffer
                sttm_pkg::OFF_DUTY_LO: st_next.buffer = I_WDATA;
                // high write moves buffer into low byte
                sttm_pkg::OFF_DUTY_HI:
                    st_next.duty = {I_WDATA[1:0], st_reg.buffer};
                default: st_next.buffer = st_next.buffer;
            endcase
        end
        // on rise clears counter and restores output
        if (on_rise) begin
            st_next.cnt = sttm_pkg::CNT_RESET;
            st_next.out = I_WDATA[sttm_pkg::C0_ON] ?
                          st_next.ctl1[sttm_pkg::C1_OC] : oc_bit;
            st_next.pulse_run = 1'b0;
        end
        // Register reads, answered in the following cycle.
        // A high-byte read refreshes the shared buffer for the next low read.
        if (I_READ) begin
            unique case (I_ADDR)
                sttm_pkg::OFF_CTL0: st_next.rdata = st_reg.ctl0;
                sttm_pkg::OFF_CTL1: st_next.rdata = st_reg.ctl1;
                sttm_pkg::OFF_CNT_LO: st_next.rdata = st_reg.buffer;
                sttm_pkg::OFF_CNT_HI: begin
                    st_next.rdata = {6'h00, st_reg.cnt[9:8]};
                    st_next.buffer = st_reg.cnt[7:0];
                end
                sttm_pkg::OFF_DUTY_LO: st_next.rdata = st_reg.buffer;
                sttm_pkg::OFF_DUTY_HI: begin
                    st_next.rdata = {6'h00, st_reg.duty[9:8]};
                    st_next.buffer = st_reg.duty[7:0];
                end
                default: st_next.rdata = 8'h00;
            endcase
        end
    end

    // State register; every field starts from a constant.
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs taken from the state flops.
    assign O_RDATA = st_reg.rdata;
    assign O_DUTY_MATCH_FLAG = st_reg.flag_a;
    assign O_PERIOD_MATCH_FLAG = st_reg.flag_p;
    assign O_TIMER_OUTPUT_PIN = st_reg.out ^ pol_bit;
    // The pin level still follows the flop while released; loads ignore it.
    // pin released in timer and capture modes
    assign O_TIMER_OUTPUT_OE_N = (mode == sttm_pkg::MODE_TMR) ||
                                 (mode == sttm_pkg::MODE_CAP);

    // Checks on the counter, the match flags, register reads and the output pin.
    // Every check is skipped while reset is held.
    a_on_rise_clear: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        $rose(on_bit) |-> (st_reg.cnt == sttm_pkg::CNT_RESET))
        else $error("Counter not cleared on switch on.");
    a_off_holds: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (!on_bit)[*2] |-> $stable(st_reg.cnt))
        else $error("Counter moved while off.");
    a_pause_holds: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (on_bit && pause_bit)[*2] |-> $stable(st_reg.cnt))
        else $error("Counter moved while paused.");
    a_sys_counts: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        (on_bit && !pause_bit && clk_sel == sttm_pkg::CK_SYS &&
         mode != sttm_pkg::MODE_PWM)[*2] ##0 !$rose(on_bit) |->
        st_reg.cnt == $past(st_reg.cnt) + 10'h001 ||
        st_reg.cnt == sttm_pkg::CNT_RESET)
        else $error("Counter did not advance on system clock.");
    a_no_per_flag: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        O_PERIOD_MATCH_FLAG |-> !($past(clr_bit) &&
        ($past(mode) == sttm_pkg::MODE_CMP ||
         $past(mode) == sttm_pkg::MODE_TMR)))
        else $error("Period flag raised while duty clears.");
    a_duty_clears: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        O_DUTY_MATCH_FLAG && $past(clr_bit) &&
        $past(mode) == sttm_pkg::MODE_CMP |-> st_reg.cnt == 10'h000)
        else $error("Duty match did not clear counter.");
    a_toggle_out: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        O_DUTY_MATCH_FLAG && $past(mode) == sttm_pkg::MODE_CMP &&
        $past(func) == sttm_pkg::FN_3 && !$rose(on_bit) |->
        st_reg.out != $past(st_reg.out))
        else $error("Output did not toggle on duty match.");
    a_timer_undriven: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        mode == sttm_pkg::MODE_TMR |-> O_TIMER_OUTPUT_OE_N)
        else $error("Output driven in timer mode.");
    a_high_read: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        I_READ && I_ADDR == sttm_pkg::OFF_CNT_HI |=>
        O_RDATA == {6'h00, $past(st_reg.cnt[9:8])} &&
        st_reg.buffer == $past(st_reg.cnt[7:0]))
        else $error("High byte read did not latch low byte.");
    // forced active level keeps the output flop at its level.
    a_pwm_forced: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        $past(on_bit) && $past(mode) == sttm_pkg::MODE_PWM &&
        $past(func) == sttm_pkg::FN_1 |-> st_reg.out == $past(oc_bit))
        else $error("Forced active level not held.");
    // disabled capture raises no duty flag.
    a_cap_disabled: assert property (
        @(posedge I_CLOCK) disable iff (!I_RESET_N)
        $past(mode) == sttm_pkg::MODE_CAP &&
        $past(func) == sttm_pkg::FN_3 |-> !O_DUTY_MATCH_FLAG)
        else $error("Duty flag raised with capture disabled.");
endmodule // sttm_timer

// File: hw/sttm_pkg.sv
// Constants, register map and field layout of the ten-bit timer.
// Assumes a byte-wide register port and a single system clock.
// What this block does
// - Ten-bit up-counter counts enabled, unpaused module clocks.
// - Period compares bits 9..7; duty compares all.
// - On rise clears counter; off holds value.
// - Pause bit holds counter, resumes afterwards.
// - Clock select picks divided, sub or external.
// - Period match at N*128, zero means 1024.
// - Clear select picks duty or period clear.
// - Clear select ignored in PWM, pulse, capture.
// - Mode bits pick compare, capture, PWM, timer.
// - Compare mode duty match drives output action.
// - PWM function bits force, waveform or pulse.
// - Capture function bits choose capture edge.
// - On rise restores output initial level.
// - Output control sets initial or active level.
// - Polarity inverts pin; also applied in timer mode.
// - Swap bit exchanges period and duty roles in PWM only.
// - Overflow or clearing match raises event pulse.
// - Timer mode leaves output pin undriven.
// - Low bytes pass through shared byte buffer.
// - No period flag when duty clears counter.
package sttm_pkg;
    // Register offsets on the byte port.
    localparam logic [2:0] OFF_CTL0 = 3'h0;
    localparam logic [2:0] OFF_CTL1 = 3'h1;
    localparam logic [2:0] OFF_CNT_LO = 3'h2;
    localparam logic [2:0] OFF_CNT_HI = 3'h3;
    localparam logic [2:0] OFF_DUTY_LO = 3'h4;
    localparam logic [2:0] OFF_DUTY_HI = 3'h5;
    // Field positions in control register 0.
    localparam int C0_PAUSE = 7;
    localparam int C0_CLK_HI = 6;
    localparam int C0_CLK_LO = 4;
    localparam int C0_ON = 3;
    localparam int C0_PER_HI = 2;
    // Field positions in control register 1.
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_FUNC_HI = 5;
    localparam int C1_FUNC_LO = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CLR = 0;
    // Reset values.
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [9:0] CNT_RESET = 10'h000;
    // Operating modes.
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    // Function codes, shared by compare, capture and PWM modes.
    localparam logic [1:0] FN_0 = 2'h0;
    localparam logic [1:0] FN_1 = 2'h1;
    localparam logic [1:0] FN_2 = 2'h2;
    localparam logic [1:0] FN_3 = 2'h3;
    // Clock select codes.
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXT_R = 3'h6;
    localparam logic [2:0] CK_EXT_F = 3'h7;
    // Divider terminal counts and period step.
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_LAST = 6'h3F;
    localparam logic [6:0] PER_LOW_ZERO = 7'h00;
    localparam logic [10:0] FULL_PERIOD = 11'h400;
endpackage

// File: sim/sttm_far_side.sv
// Far-side pin model: external clock source, capture source, output load.
// Assumes it shares the system clock and is driven from bench tasks.
`timescale 1ns/1ps
module sttm_far_side (
    // System clock.
    input wire logic i_clock,
    // Output pin of the timer and its enable.
    input wire logic i_pin,
    input wire logic i_oe_n,
    // Pins that the model drives.
    output logic o_ext_clk,
    output logic o_capture,
    output logic o_pin_level
);
    // Both input pins idle low until a task moves them.
    initial begin
        o_ext_clk = 1'b0;
        o_capture = 1'b0;
    end

    // a released pin floats to the pull-up.
    assign o_pin_level = i_oe_n ? 1'b1 : i_pin;

    task automatic ext_pulses(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clock) o_ext_clk <= 1'b1;
            repeat (4) @(posedge i_clock);
            o_ext_clk <= 1'b0;
            repeat (4) @(posedge i_clock);
        end
    endtask

    // Moves the capture pin just after a clock edge.
    task automatic cap_set(input logic v);
        @(posedge i_clock) o_capture <= v;
    endtask
endmodule // sttm_far_side

// File: sim/tb.sv
// Self-checking bench: registers, counting, compare, PWM and capture.
// Assumes the far-side pin model and the timer package are compiled first.
`timescale 1ns/1ps
module tb;
    // Design inputs, each with a value at time zero.
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic tick_ph = 1'b0;
    // Design outputs and pin levels.
    wire logic [7:0] rdata;
    wire logic ext_clk, cap_pin, pin, oe_n, dflag, pflag, pin_lvl;
    // Counts of checks, cycles, flags and high pin cycles.
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    int nd = 0;
    int np = 0;
    int nh = 0;

    always #2 clk = ~clk;
    // Tick sources run at half the system rate, from one phase flop.
    wire logic hi_tick, sub_tick;
    assign hi_tick = tick_ph;
    assign sub_tick = tick_ph;
    always @(posedge clk) begin
        tick_ph <= ~tick_ph;
    end
    // Counters sample on the falling edge, clear of the launching edge.
    always @(negedge clk) begin
        cyc++;
        nd += (dflag === 1'b1);
        np += (pflag === 1'b1);
        nh += (pin_lvl === 1'b1);
    end

    sttm_timer dut_u (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WRITE(wr_s), .I_READ(rd_s), .O_RDATA(rdata),
        .I_HIGH_CLK_TICK(hi_tick), .I_SUB_CLK_TICK(sub_tick),
        .I_EXTERNAL_CLOCK_PIN(ext_clk), .I_CAPTURE_INPUT_PIN(cap_pin),
        .O_TIMER_OUTPUT_PIN(pin), .O_TIMER_OUTPUT_OE_N(oe_n),
        .O_DUTY_MATCH_FLAG(dflag), .O_PERIOD_MATCH_FLAG(pflag));
    sttm_far_side far_u (.i_clock(clk), .i_pin(pin), .i_oe_n(oe_n),
        .o_ext_clk(ext_clk), .o_capture(cap_pin), .o_pin_level(pin_lvl));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input string n, input logic [15:0] s, e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle write strobe beside address and data.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
    endtask
    // One-cycle read strobe; data stand in the following cycle only.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, string n);
        logic [7:0] d;
        rd(a, d);
        chk(n, {8'h00, d}, {8'h00, e});
    endtask
    // Reads the counter high byte first so the low byte is latched.
    task automatic cchk(input logic [9:0] e, input string n);
        logic [7:0] h, l;
        rd(sttm_pkg::OFF_CNT_HI, h);
        rd(sttm_pkg::OFF_CNT_LO, l);
        chk(n, {h, l}, {6'h00, e});
    endtask
    // mode and function change only while off.
    task automatic setup(input logic [7:0] c1, c0);
        wr(sttm_pkg::OFF_CTL0, c0 & 8'hF7);
        wr(sttm_pkg::OFF_CTL1, c1);
        wr(sttm_pkg::OFF_CTL0, c0);
    endtask
    task automatic duty(input logic [9:0] v);
        wr(sttm_pkg::OFF_DUTY_LO, v[7:0]);
        wr(sttm_pkg::OFF_DUTY_HI, {6'h00, v[9:8]});
    endtask
    // Waits, within a bound, for the next duty or period flag.
    task automatic wait_flag(input bit d);
        int n0;
        n0 = d ? nd : np;
        for (int i = 0; i < 40000 && (d ? nd : np) == n0; i++) @(posedge clk);
    endtask
    // Cycles between two flags, and the other flag's count meanwhile.
    task automatic meas(input bit d, output int iv, output int ot);
        int t0, o0;
        wait_flag(d);
        t0 = cyc;
        o0 = d ? np : nd;
        wait_flag(d);
        iv = cyc - t0;
        ot = (d ? np : nd) - o0;
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog sized well above the longest expected run.
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        final_report;
    end

    initial begin
        int iv, ot, h0;
        logic [7:0] c0s [8];
        int pex [8];
        logic [7:0] cm [5];
        logic [1:0] cx [5];
        logic [7:0] p1 [5];
        logic [7:0] p0 [5];
        int pw [5];
        int ph [5];
        logic [1:0] cap [4];
        logic [7:0] capv [4];
        c0s = '{{1'b0, sttm_pkg::CK_SYS, 4'h9}, {1'b0, sttm_pkg::CK_SYS4, 4'h9},
            {1'b0, sttm_pkg::CK_H16, 4'h9}, {1'b0, sttm_pkg::CK_H64, 4'h9},
            {1'b0, sttm_pkg::CK_SUB0, 4'h9}, {1'b0, sttm_pkg::CK_SUB1, 4'h9},
            {1'b0, sttm_pkg::CK_SYS, 4'h8}, {1'b0, sttm_pkg::CK_SYS, 4'hF}};
        pex = '{128, 512, 4096, 16384, 256, 256, 1024, 896};
        // actions differ from the starting level, except pass 0 with no action.
        cm = '{8'h00, 8'h18, 8'h20, 8'h30, 8'h1C};
        cx = '{2'b00, 2'b10, 2'b01, 2'b01, 2'b01};
        p1 = '{8'hA8, 8'hAC, 8'h88, 8'h98, 8'hAA};
        p0 = '{8'h1A, 8'h1A, 8'h1A, 8'h1A, 8'h19};
        pw = '{256, 256, 256, 256, 200};
        ph = '{200, 56, 0, 256, 128};
        cap = '{2'b10, 2'b01, 2'b11, 2'b00};
        // Captured counts: i+1 pulses, the disabled pass keeps the last.
        capv = '{8'h01, 8'h02, 8'h03, 8'h03};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rchk(sttm_pkg::OFF_CTL0, sttm_pkg::CTL_RESET, "ctl0");
        rchk(sttm_pkg::OFF_CTL1, sttm_pkg::CTL_RESET, "ctl1");
        rchk(3'h6, 8'h00, "unmapped");
        wr(sttm_pkg::OFF_CNT_LO, 8'h55);
        rchk(sttm_pkg::OFF_CNT_LO, 8'h00, "count lo ro");
        cchk(10'h000, "count ro");
        duty(10'h2A5);
        rchk(sttm_pkg::OFF_DUTY_HI, 8'h02, "duty hi");
        rchk(sttm_pkg::OFF_DUTY_LO, 8'hA5, "duty lo");
        $display("test registers done");
        setup(8'hC0, {1'b0, sttm_pkg::CK_EXT_R, 4'h8});
        chk("oe_n timer", {15'h0, oe_n}, 16'h1);
        far_u.ext_pulses(5);
        cchk(10'd5, "ext rise");
        wr(sttm_pkg::OFF_CTL0, {1'b1, sttm_pkg::CK_EXT_R, 4'h8});
        far_u.ext_pulses(3);
        cchk(10'd5, "paused");
        wr(sttm_pkg::OFF_CTL0, {1'b0, sttm_pkg::CK_EXT_F, 4'h8});
        far_u.ext_pulses(2);
        cchk(10'd7, "ext fall");
        wr(sttm_pkg::OFF_CTL0, {1'b0, sttm_pkg::CK_EXT_F, 4'h0});
        far_u.ext_pulses(2);
        cchk(10'd7, "off holds");
        wr(sttm_pkg::OFF_CTL0, {1'b0, sttm_pkg::CK_EXT_F, 4'h8});
        cchk(10'd0, "on clears");
        $display("test counting done");
        for (int i = 0; i < 8; i++) begin
            setup(8'h00, c0s[i]);
            meas(1'b0, iv, ot);
            chk("period", iv[15:0], pex[i][15:0]);
        end
        $display("test clock select done");
        duty(10'd200);
        setup(8'h01, {1'b0, sttm_pkg::CK_SYS, 4'h9});
        meas(1'b1, iv, ot);
        chk("duty clear", iv[15:0], 16'd200);
        chk("no period flag", ot[15:0], 16'd0);
        setup(8'hA9, {1'b0, sttm_pkg::CK_SYS, 4'h9});
        meas(1'b0, iv, ot);
        chk("pwm clear", iv[15:0], 16'd128);
        for (int i = 0; i < 5; i++) begin
            setup(p1[i], p0[i]);
            repeat (300) @(posedge clk);
            h0 = nh;
            repeat (pw[i]) @(posedge clk);
            chk("pwm high", 16'(nh - h0), ph[i][15:0]);
        end
        // single pulse waits for a trigger, ends on duty match.
        setup(8'hB8, {1'b0, sttm_pkg::CK_SYS, 4'h8});
        cchk(10'd0, "pulse idle");
        far_u.ext_pulses(1);
        repeat (220) @(posedge clk);
        chk("pulse end", {15'h0, pin_lvl}, 16'h0);
        cchk(10'd200, "pulse length");
        $display("test pwm done");
        duty(10'd64);
        for (int i = 0; i < 5; i++) begin
            setup(cm[i], {1'b0, sttm_pkg::CK_SYS, 4'h9});
            repeat (4) @(negedge clk);
            chk("pin init", {15'h0, pin_lvl}, {15'h0, cx[i][1]});
            wait_flag(1'b1);
            repeat (2) @(negedge clk);
            chk("pin action", {15'h0, pin_lvl}, {15'h0, cx[i][0]});
        end
        $display("test compare done");
        for (int i = 0; i < 4; i++) begin
            setup({sttm_pkg::MODE_CAP, 2'(i), 4'h0},
                {1'b0, sttm_pkg::CK_EXT_R, 4'h8});
            far_u.ext_pulses(i + 1);
            h0 = nd;
            far_u.cap_set(1'b1);
            repeat (8) @(posedge clk);
            chk("capture rise", 16'(nd - h0), {15'h0, cap[i][1]});
            h0 = nd;
            far_u.cap_set(1'b0);
            repeat (8) @(posedge clk);
            chk("capture fall", 16'(nd - h0), {15'h0, cap[i][0]});
            rchk(sttm_pkg::OFF_DUTY_HI, 8'h00, "capture hi");
            rchk(sttm_pkg::OFF_DUTY_LO, capv[i], "capture lo");
        end
        $display("test capture done");
        final_report;
    end
endmodule // tb
